// ==== bench/bts_burst_tx_chk.sv ====
// Concurrent checks on the ports of the burst transmit sequencer.
`timescale 1ns/1ps
module bts_burst_tx_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic cts_out,
  input wire logic carrier_on,
  input wire logic i_bit,
  input wire logic q_bit,
  input wire logic sym_strobe
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Handshake and link relations; each ties an output to its cause.
  AST_CTS_RST: assert property ($rose(aresetn) |-> cts_out)
    else $error("cts low after reset");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  AST_AR_ANS: assert property (s_axi_arvalid && s_axi_arready |=> !s_axi_arready && s_axi_rvalid)
    else $error("read answer late");
  AST_CW_ONES: assert property ($rose(carrier_on) |-> i_bit && q_bit)
    else $error("carrier not all ones");
  AST_END_IDLE: assert property ($rose(cts_out) |-> !carrier_on)
    else $error("carrier on after burst");
  AST_CTS_BURST: assert property (!cts_out |-> carrier_on)
    else $error("cts low outside burst");
  AST_PRE_SAME: assert property (carrier_on && cts_out |-> i_bit == q_bit)
    else $error("preamble channels differ");
  AST_STB_PULSE: assert property (sym_strobe |=> !sym_strobe)
    else $error("strobe longer than one cycle");
  AST_SYM_STB: assert property (carrier_on && $past(carrier_on) && ($changed(i_bit) ||
    $changed(q_bit)) |-> ##[0:1] sym_strobe)
    else $error("symbol change without strobe");

  // Main scenarios.
  COV_BURST: cover property ($rose(carrier_on));
  COV_GRANT: cover property ($fell(cts_out));
  COV_WRITE: cover property (s_axi_bvalid && s_axi_bready);
endmodule // bts_burst_tx_chk

// ==== bench/bts_burst_tx_tb.sv ====
// Self-checking bench: register access, bit clock rates and complete bursts.
`timescale 1ns/1ps
`include "bts_defs.svh"
module bts_burst_tx_tb;
  localparam logic [30:0] UW = 31'h23a979b;
  localparam logic [30:0] UWP = 31'h6cf4ae20;
  localparam logic [63:0] PAT = 64'h9d2c_5681_e3b7_a04f;
  logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic [3:0] s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [1:0] s_axi_bresp, s_axi_rresp, symq[$];
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, go, done;
  logic tx_clk_in, tx_data_in, rts_in, cts_out, internal_send_clock, carrier_on, i_bit, q_bit;
  logic sym_strobe, exact;
  logic [5:0] hist;
  int err_total, check_count, diff, n;

  // Short relock count keeps the frequency reply test brief.
  bts_burst_tx #(.RELOCK_CYC(20)) i_bts_burst_tx (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tx_clk_in(tx_clk_in),
    .tx_data_in(tx_data_in), .rts_in(rts_in), .cts_out(cts_out),
    .internal_send_clock(internal_send_clock), .carrier_on(carrier_on), .i_bit(i_bit),
    .q_bit(q_bit), .sym_strobe(sym_strobe));
  bts_far_end #(.NBITS(48), .PAT(PAT)) i_bts_far_end (.go(go), .cts_out(cts_out),
    .rts_in(rts_in), .tx_clk_in(tx_clk_in), .tx_data_in(tx_data_in), .done(done));

  // 50 ns system clock.
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  // Every loaded symbol pair is queued for the burst checks.
  always @(posedge aclk) if (sym_strobe === 1'b1) symq.push_back({i_bit, q_bit});

  task cmp_word(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task cmp_sym(input logic [1:0] got, input logic [1:0] exp);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Write: address and data offered together, each released when taken.
  task axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        cmp_word(s_axi_bresp, `BTS_RESP_OKAY);
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask

  task rd_chk(input logic [3:0] a, input logic [31:0] mask, input logic [31:0] exp);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd = s_axi_rdata;
        cmp_word(s_axi_rresp, `BTS_RESP_OKAY);
        s_axi_rready <= 1'b0;
        break;
      end
    end
    cmp_word(rd & mask, exp);
  endtask

  // Counts system clock edges up to the next rising edge of the send clock.
  task wait_rise(inout int cnt);
    logic p;
    p = internal_send_clock;
    for (int k = 0; k < 3000; k++) begin
      @(posedge aclk);
      cnt++;
      if (internal_send_clock === 1'b1 && p === 1'b0) break;
      p = internal_send_clock;
    end
  endtask

  // Segment kinds: 0 carrier, 1 training, 2 unique word, 3 payload, 4 flush, 5 postamble.
  // With a live scrambler the coded symbols cannot be predicted, so only a difference counts.
  task seg(input int cnt, input int kind);
    logic [1:0] e;
    logic [6:0] sr;
    for (int k = 0; k < cnt; k++) begin
      sr = {(kind == 3) ? PAT[k] : 1'b0, hist};
      case (kind)
        0: e = 2'b11;
        1: e = {2{~k[0]}};
        2: e = {2{UW[30-k]}};
        5: e = {2{UWP[30-(k%31)]}};
        default: begin
          e = {^(sr & `BTS_G1_TAPS), ^(sr & `BTS_G2_TAPS)};
          hist = sr[6:1];
        end
      endcase
      if (!exact && (kind == 3 || kind == 4)) diff += int'(symq[0] !== e);
      else cmp_sym(symq[0], e);
      void'(symq.pop_front());
    end
  endtask

  task burst(input logic [31:0] ctrl, input logic [31:0] seed, input int cw, input logic ex);
    axi_wr(`BTS_CTRL_OFS, ctrl);
    axi_wr(`BTS_SEED_OFS, seed);
    symq.delete();
    hist = '0;
    diff = 0;
    exact = ex;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    for (int k = 0; k < 20000 && done !== 1'b1; k++) @(posedge aclk);
    cmp_word(symq.size(), cw + 352 + 31 + 48 + 6 + 62);
    seg(cw, 0);
    seg(352, 1);
    seg(31, 2);
    seg(48, 3);
    seg(6, 4);
    seg(62, 5);
    cmp_word({cts_out, carrier_on}, 32'h2);
    if (!ex) cmp_word(diff != 0, 32'h1);
  endtask

  task test_done();
    if (err_total == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // A hang counts as a mismatch and ends the run in the same place.
  initial begin
    repeat (60000) @(posedge aclk);
    err_total++;
    test_done();
  end

  // Main sequence.
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, go} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, rd} = '0;
    s_axi_wstrb = 4'hf;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd_chk(`BTS_CTRL_OFS, 32'hffff_ffff, `BTS_CTRL_RST);
    rd_chk(`BTS_SEED_OFS, 32'hffff_ffff, `BTS_SEED_RST);
    axi_wr(`BTS_STATUS_OFS, 32'h0);
    rd_chk(`BTS_STATUS_OFS, 32'h18ff, 32'h81);
    axi_wr(`BTS_FREQ_OFS, 32'h1);
    rd_chk(`BTS_STATUS_OFS, 32'h800, 32'h800);
    repeat (30) @(posedge aclk);
    rd_chk(`BTS_STATUS_OFS, 32'h800, 32'h0);
    rd_chk(`BTS_FREQ_OFS, 32'hffff_ffff, 32'h0);
    wait_rise(n);
    n = 0;
    wait_rise(n);
    cmp_word(n, `BTS_DIV_SLOW);
    axi_wr(`BTS_CTRL_OFS, 32'h2);
    rd_chk(`BTS_STATUS_OFS, 32'h1000, 32'h1000);
    wait_rise(n);
    n = 0;
    wait_rise(n);
    cmp_word(n, `BTS_DIV_FAST);
    burst(32'h1, 32'h0, 96, 1'b1);
    repeat (2200) @(posedge aclk);
    rd_chk(`BTS_STATUS_OFS, 32'h100, 32'h100);
    rd_chk(`BTS_STATUS_OFS, 32'h600, 32'h0);
    burst(32'h7, 32'h0, 288, 1'b1);
    burst(32'h5, `BTS_SEED_RST, 96, 1'b0);
    test_done();
  end
endmodule // bts_burst_tx_tb

bind bts_burst_tx bts_burst_tx_chk i_bts_burst_tx_chk (.aclk(aclk), .aresetn(aresetn),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .cts_out(cts_out), .carrier_on(carrier_on), .i_bit(i_bit), .q_bit(q_bit),
  .sym_strobe(sym_strobe));

// ==== bench/bts_far_end.sv ====
// Behavioural terrestrial equipment: request handshake, bit clock and data.
`timescale 1ns/1ps
module bts_far_end #(
  parameter int NBITS = 48,
  parameter logic [63:0] PAT = 64'h0
) (
  input wire logic go,
  input wire logic cts_out,
  output logic rts_in,
  output logic tx_clk_in,
  output logic tx_data_in,
  output logic done
);
  // One 400 ns bit period; data moves just after the falling edge.
  task automatic cyc();
    #200 tx_clk_in = 1'b1;
    #200 tx_clk_in = 1'b0;
  endtask

  // The clock stands still between bursts, so the block must fall back to its own clock.
  // Outside the payload the data line toggles so a stale bit is never mistaken for data.
  initial begin
    {rts_in, tx_clk_in, tx_data_in, done} = 4'h0;
    forever begin
      @(posedge go);
      done = 1'b0;
      #37 rts_in = 1'b1;
      do begin
        tx_data_in = ~tx_data_in;
        cyc();
      end while (cts_out);
      for (int k = 0; k < NBITS; k++) begin
        tx_data_in = PAT[k];
        cyc();
      end
      rts_in = 1'b0;
      do begin
        tx_data_in = ~tx_data_in;
        cyc();
      end while (!cts_out);
      done = 1'b1;
    end
  end
endmodule // bts_far_end

// ==== design/bts_burst_tx.sv ====
// Burst transmit sequencer with its AXI4-Lite register slave.
// Function
// - Bit clock from terrestrial or internal source
// - Lost clock activity falls back to internal
// - Carrier 96 or 288 periods after RTS
// - Then 352 periods of clock training
// - Then 31-bit unique word ends preamble
// - CTS false; next bit is first payload
// - RTS low: flush encoder with 6 bits
// - Then unique word prime twice, 62 bits
// - Then CTS true, ready for next burst
// - Seeded 2^15-1 scrambler or bypass, selectable
// - No differential encoding in burst mode
// - Rate 1/2, K=7 convolutional encoder
// - Encoder outputs feed I and Q separately
// - Report missing activity on I or Q
// - Rate 19.2 or 57.6 kbps, symbol rate follows
// - Frequency change reply within 200 ms
// - Carrier segment sends ones on I and Q
// - Training 1010 and unique word uncoded BPSK
// - Unique word identical on both channels
// - Unique word prime identical on both channels
`timescale 1ns/1ps
`include "bts_defs.svh"

module bts_burst_tx import bts_pkg::*; #(
  parameter int unsigned RELOCK_CYC = `BTS_FREQ_CYC - 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [3:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [3:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic tx_clk_in,
  input wire logic tx_data_in,
  input wire logic rts_in,
  output logic cts_out,
  output logic internal_send_clock,
  output logic carrier_on,
  output logic i_bit,
  output logic q_bit,
  output logic sym_strobe
);

  // Byte-lane merge of a write into a stored word.
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    return (old & ~m) | (nw & m);
  endfunction

  // Picks bit idx of a 31-bit pattern, most significant bit first.
  function automatic logic pat_bit(input logic [30:0] pat, input logic [8:0] idx);
    logic [4:0] pos;
    pos = 5'd30 - idx[4:0];
    return pat[pos];
  endfunction

  logic [31:0] ctrl_q, seed_q;
  logic [3:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  logic aw_got_q, w_got_q;
  logic [22:0] relock_q;
  logic tclk_s1_q, tclk_s2_q, tclk_s3_q;
  logic rts_s1_q, rts_s2_q, rts_s3_q;
  logic txd_s1_q, txd_s2_q;
  logic [10:0] div_q;
  logic [11:0] loss_q;
  logic fallback_q;
  logic rts_rise_q;
  bts_state_e st_q, st_d;
  logic [8:0] seg_q;
  logic [14:0] lfsr_q;
  logic [5:0] enc_q;
  logic [1:0] idle_flag;

  wire sel_ext = ctrl_q[`BTS_CTRL_EXT_BIT];
  wire sel_fast = ctrl_q[`BTS_CTRL_FAST_BIT];
  wire scr_en = ctrl_q[`BTS_CTRL_SCR_BIT];

  // Write side of the bus: address and data are taken in either order, answer follows both.
  wire aw_take = s_axi_awvalid & s_axi_awready;
  wire w_take = s_axi_wvalid & s_axi_wready;
  wire wr_do = aw_got_q & w_got_q & ~s_axi_bvalid;
  wire aw_got_d = (aw_got_q | aw_take) & ~wr_do;
  wire w_got_d = (w_got_q | w_take) & ~wr_do;
  wire bvalid_d = wr_do | (s_axi_bvalid & ~s_axi_bready);
  wire wr_ctrl = wr_do & (awaddr_q == `BTS_CTRL_OFS);
  wire wr_seed = wr_do & (awaddr_q == `BTS_SEED_OFS);
  wire wr_freq = wr_do & (awaddr_q == `BTS_FREQ_OFS);
  wire wr_ok = wr_ctrl | wr_seed | wr_freq | (awaddr_q == `BTS_STATUS_OFS);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `BTS_RESP_OKAY;
      awaddr_q <= 4'h0;
      wdata_q <= 32'h0;
      wstrb_q <= 4'h0;
    end else begin
      aw_got_q <= aw_got_d;
      w_got_q <= w_got_d;
      s_axi_awready <= ~aw_got_d & ~bvalid_d;
      s_axi_wready <= ~w_got_d & ~bvalid_d;
      s_axi_bvalid <= bvalid_d;
      if (aw_take) awaddr_q <= {s_axi_awaddr[3:2], 2'b00};
      if (w_take) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (wr_do) s_axi_bresp <= wr_ok ? `BTS_RESP_OKAY : `BTS_RESP_SLVERR;
    end
  end

  // Configuration registers; a write to the frequency register starts the relock reply timer.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= `BTS_CTRL_RST;
      seed_q <= `BTS_SEED_RST;
      relock_q <= 23'h0;
    end else begin
      if (wr_ctrl) ctrl_q <= merge(ctrl_q, wdata_q, wstrb_q) & 32'h0000_0007;
      if (wr_seed) seed_q <= merge(seed_q, wdata_q, wstrb_q) & 32'h0000_7fff;
      if (wr_freq) relock_q <= 23'(RELOCK_CYC);
      else if (relock_q != 23'h0) relock_q <= relock_q - 23'h1;
    end
  end

  // Read side: one read at a time, data captured when the address is taken.
  wire ar_take = s_axi_arvalid & s_axi_arready;
  wire rvalid_d = ar_take | (s_axi_rvalid & ~s_axi_rready);
  wire [3:0] ar_word = {s_axi_araddr[3:2], 2'b00};
  wire [31:0] status_w = {19'h0, sel_fast, relock_q != 23'h0, idle_flag[1], idle_flag[0],
                          fallback_q, cts_out, st_q};
  wire ar_ok = (ar_word == `BTS_CTRL_OFS) | (ar_word == `BTS_SEED_OFS) |
               (ar_word == `BTS_STATUS_OFS) | (ar_word == `BTS_FREQ_OFS);
  wire [31:0] rd_mux = (ar_word == `BTS_CTRL_OFS) ? ctrl_q :
                       (ar_word == `BTS_SEED_OFS) ? seed_q :
                       (ar_word == `BTS_STATUS_OFS) ? status_w : 32'h0;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `BTS_RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_d;
      s_axi_rvalid <= rvalid_d;
      if (ar_take) begin
        s_axi_rdata <= rd_mux;
        s_axi_rresp <= ar_ok ? `BTS_RESP_OKAY : `BTS_RESP_SLVERR;
      end
    end
  end

  // Pin synchronisers; only the second and third stages feed any logic.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tclk_s1_q <= 1'b0;
      tclk_s2_q <= 1'b0;
      tclk_s3_q <= 1'b0;
      rts_s1_q <= 1'b0;
      rts_s2_q <= 1'b0;
      rts_s3_q <= 1'b0;
      txd_s1_q <= 1'b0;
      txd_s2_q <= 1'b0;
    end else begin
      tclk_s1_q <= tx_clk_in;
      tclk_s2_q <= tclk_s1_q;
      tclk_s3_q <= tclk_s2_q;
      rts_s1_q <= rts_in;
      rts_s2_q <= rts_s1_q;
      rts_s3_q <= rts_s2_q;
      txd_s1_q <= tx_data_in;
      txd_s2_q <= txd_s1_q;
    end
  end

  // Internal send clock divider; its period follows the selected data rate.
  wire [10:0] div_last = sel_fast ? 11'(`BTS_DIV_FAST - 1) : 11'(`BTS_DIV_SLOW - 1);
  wire int_tick = (div_q >= div_last);
  wire ext_edge = tclk_s2_q & ~tclk_s3_q;
  wire use_ext = sel_ext & ~fallback_q;
  // Data is sampled on the same edge as the chosen clock, so the far end's clock paces the burst when it is selected.
  wire bit_tick = use_ext ? ext_edge : int_tick;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_q <= 11'h0;
      internal_send_clock <= 1'b0;
    end else begin
      div_q <= int_tick ? 11'h0 : div_q + 11'h1;
      internal_send_clock <= (div_q < {1'b0, div_last[10:1]});
    end
  end

  // Activity detector on the terrestrial clock; two slow bit periods without an edge is a fault.
  // Recovery is automatic once edges return, so a reconnected cable needs no software action.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loss_q <= 12'h0;
      fallback_q <= 1'b0;
    end else if (ext_edge) begin
      loss_q <= 12'h0;
      fallback_q <= 1'b0;
    end else if (loss_q >= 12'(`BTS_LOSS_CYC)) begin
      fallback_q <= 1'b1;
    end else begin
      loss_q <= loss_q + 12'h1;
    end
  end

  // Segment length for the current state, counted in bit periods.
  wire [8:0] cw_len = sel_fast ? `BTS_CW_FAST : `BTS_CW_SLOW;
  wire [8:0] seg_len = (st_q == BTS_CARRIER) ? cw_len :
                       (st_q == BTS_TRAIN) ? `BTS_TRAIN_LEN :
                       (st_q == BTS_UWORD) ? `BTS_UW_LEN :
                       (st_q == BTS_FLUSH) ? `BTS_FLUSH_LEN : `BTS_POST_LEN;
  wire seg_last = (seg_q == seg_len - 9'h1);
  wire rts_hi = rts_s3_q;

  // Burst sequence; every step happens on a bit-clock tick.
  always_comb begin
    st_d = st_q;
    if (bit_tick) begin
      unique case (st_q)
        BTS_IDLE: if (rts_rise_q) st_d = BTS_CARRIER;
        BTS_CARRIER: if (seg_last) st_d = BTS_TRAIN;
        BTS_TRAIN: if (seg_last) st_d = BTS_UWORD;
        BTS_UWORD: if (seg_last) st_d = BTS_PAYLOAD;
        BTS_PAYLOAD: if (!rts_hi) st_d = BTS_FLUSH;
        BTS_FLUSH: if (seg_last) st_d = BTS_POST;
        BTS_POST: if (seg_last) st_d = BTS_IDLE;
      endcase
    end
  end

  // Rising edge of RTS is remembered until idle; an edge that lands on the clearing tick is kept.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rts_rise_q <= 1'b0;
    end else if (rts_s2_q & ~rts_s3_q) begin
      rts_rise_q <= 1'b1;
    end else if (bit_tick & (st_q == BTS_IDLE)) begin
      rts_rise_q <= 1'b0;
    end
  end

  // Payload path: scrambler output and encoder input for this tick.
  wire lfsr_fb = lfsr_q[14] ^ lfsr_q[13];
  wire pay_bit = scr_en ? (txd_s2_q ^ lfsr_fb) : txd_s2_q;
  wire enc_in = (st_q == BTS_PAYLOAD) & rts_hi & pay_bit; // Zero while flushing.
  wire [6:0] enc_vec = {enc_in, enc_q};
  wire g1_bit = ^(enc_vec & `BTS_G1_TAPS);
  wire g2_bit = ^(enc_vec & `BTS_G2_TAPS);
  wire [8:0] post_idx = (seg_q >= `BTS_UW_LEN) ? seg_q - `BTS_UW_LEN : seg_q;
  wire pre_bit = (st_q == BTS_CARRIER) ? 1'b1 :
                 (st_q == BTS_TRAIN) ? ~seg_q[0] :
                 (st_q == BTS_UWORD) ? pat_bit(`BTS_UW_PAT, seg_q) :
                 pat_bit(`BTS_UWP_PAT, post_idx);
  wire coded = (st_q == BTS_PAYLOAD) | (st_q == BTS_FLUSH);
  // The tick that finds RTS low already sends flush bit 0, so no symbol period is wasted.
  wire sending = coded;

  // Sequencer registers and channel outputs.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_q <= BTS_IDLE;
      seg_q <= 9'h0;
      lfsr_q <= 15'h0;
      enc_q <= 6'h0;
      cts_out <= 1'b1;
      carrier_on <= 1'b0;
      i_bit <= 1'b0;
      q_bit <= 1'b0;
      sym_strobe <= 1'b0;
    end else begin
      st_q <= st_d;
      // A tick loads the symbol of the state it finds, so the last postamble bit gets a full period.
      sym_strobe <= bit_tick & (st_q != BTS_IDLE);
      if (bit_tick) begin
        // Flush restarts at 1 because the payload's closing tick carried flush bit 0.
        seg_q <= (st_d == st_q) ? seg_q + 9'h1 : (st_d == BTS_FLUSH) ? 9'h1 : 9'h0;
        carrier_on <= (st_q != BTS_IDLE);
        if (st_d == BTS_PAYLOAD && st_q == BTS_UWORD) cts_out <= 1'b0;
        if (st_q == BTS_IDLE) cts_out <= 1'b1;
        if (st_q == BTS_IDLE && st_d == BTS_CARRIER) begin
          lfsr_q <= seed_q[14:0];
          enc_q <= 6'h0;
        end
        if (sending) begin
          enc_q <= enc_vec[6:1];
          if (st_q == BTS_PAYLOAD && rts_hi && scr_en) lfsr_q <= {lfsr_q[13:0], lfsr_fb};
          i_bit <= g1_bit;
          q_bit <= g2_bit;
        end else if (st_q == BTS_IDLE) begin
          i_bit <= 1'b0;
          q_bit <= 1'b0;
        end else begin
          i_bit <= pre_bit;
          q_bit <= pre_bit;
        end
      end
    end
  end

  // Shaping-path activity: a channel with no transition for a window of payload symbols
  // is flagged. Preamble segments are exempt because the carrier segment is constant by design.
  logic [1:0] chan_bit;
  assign chan_bit = {q_bit, i_bit};
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_act
      logic prev_q;
      logic [6:0] quiet_q;
      logic idle_q;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          prev_q <= 1'b0;
          quiet_q <= 7'h0;
          idle_q <= 1'b0;
        end else begin
          prev_q <= chan_bit[ch];
          if (prev_q != chan_bit[ch]) begin
            quiet_q <= 7'h0;
            idle_q <= 1'b0;
          end else if (sym_strobe & coded) begin
            if (quiet_q >= `BTS_ACT_WIN) idle_q <= 1'b1;
            else quiet_q <= quiet_q + 7'h1;
          end
        end
      end
      assign idle_flag[ch] = idle_q;
    end
  endgenerate

endmodule // bts_burst_tx

// ==== design/bts_defs.svh ====
// Offsets, field positions, reset values and timing counts of the burst transmit sequencer.
`ifndef BTS_DEFS_SVH
`define BTS_DEFS_SVH

// Register byte addresses on the AXI4-Lite bus.
`define BTS_CTRL_OFS 4'h0
`define BTS_SEED_OFS 4'h4
`define BTS_STATUS_OFS 4'h8
`define BTS_FREQ_OFS 4'hc

// Control register fields.
`define BTS_CTRL_EXT_BIT 0
`define BTS_CTRL_FAST_BIT 1
`define BTS_CTRL_SCR_BIT 2
`define BTS_CTRL_RST 32'h0000_0004
`define BTS_SEED_RST 32'h0000_7fff

// Status register fields.
`define BTS_ST_STATE_LSB 0
`define BTS_ST_CTS_BIT 7
`define BTS_ST_FALLBACK_BIT 8
`define BTS_ST_I_IDLE_BIT 9
`define BTS_ST_Q_IDLE_BIT 10
`define BTS_ST_BUSY_BIT 11
`define BTS_ST_FAST_BIT 12

// AXI responses.
`define BTS_RESP_OKAY 2'h0
`define BTS_RESP_SLVERR 2'h2

// Clock rate and bit rates, and the divider counts derived from them.
`define BTS_CLK_HZ 20000000
`define BTS_RATE_SLOW_BPS 19200
`define BTS_RATE_FAST_BPS 57600
`define BTS_DIV_SLOW (`BTS_CLK_HZ / `BTS_RATE_SLOW_BPS)
`define BTS_DIV_FAST (`BTS_CLK_HZ / `BTS_RATE_FAST_BPS)
`define BTS_LOSS_CYC (2 * `BTS_DIV_SLOW)

// Segment lengths in bit periods.
`define BTS_CW_SLOW 9'h060
`define BTS_CW_FAST 9'h120
`define BTS_TRAIN_LEN 9'h160
`define BTS_UW_LEN 9'h01f
`define BTS_FLUSH_LEN 9'h006
`define BTS_POST_LEN 9'h03e

// Preamble and postamble patterns, sent most significant bit first.
`define BTS_UW_PAT 31'h023a979b
`define BTS_UWP_PAT 31'h6cf4ae20

// Encoder generator taps over {new bit, six older bits}.
`define BTS_G1_TAPS 7'h79
`define BTS_G2_TAPS 7'h5b

// Symbol periods without a transition before a channel counts as idle.
`define BTS_ACT_WIN 7'h40

// Frequency change reply time.
`define BTS_FREQ_MS 200
`define BTS_FREQ_CYC ((`BTS_CLK_HZ / 1000) * `BTS_FREQ_MS)

`endif

// ==== design/bts_pkg.sv ====
// Types shared by the burst transmit sequencer.
package bts_pkg;

  // Burst sequence states, one-hot.
  typedef enum logic [6:0] {
    BTS_IDLE    = 7'b000_0001,
    BTS_CARRIER = 7'b000_0010,
    BTS_TRAIN   = 7'b000_0100,
    BTS_UWORD   = 7'b000_1000,
    BTS_PAYLOAD = 7'b001_0000,
    BTS_FLUSH   = 7'b010_0000,
    BTS_POST    = 7'b100_0000
  } bts_state_e;

endpackage
